// *** design/psd_pkg.sv ***
// Purpose: Shared constants for the synthesizer divider control block
// Assumes: One 10 MHz system clock; all pins sampled into that domain
// Notes:   Field positions follow the 18-bit programming word layout
package psd_pkg;
  localparam int SHIFT_W       = 18;
  localparam int FB_W          = 17;
  localparam int REF_W         = 14;
  localparam int RCNT_W        = 10;
  localparam int RCNT_LSB      = 1;
  localparam int CPTRI_BIT     = 11;
  localparam int PDPOL_BIT     = 12;
  localparam int LOCKSRC_LSB   = 13;
  localparam int FB_B_W        = 10;
  localparam int FB_A_W        = 5;
  localparam int FB_B_LSB      = 7;
  localparam int FB_A_LSB      = 2;
  localparam int FB_PWDN_BIT   = 1;
  localparam int PRESC_LOW     = 32;
  localparam logic [9:0]  RCNT_MIN   = 10'h002;
  localparam logic [16:0] FB_RESET   = 17'h00000;
  localparam logic [13:0] REF_RESET  = 14'h0000;
  localparam logic [2:0] LOCKSRC_DIGITAL = 3'h0;
  localparam logic [2:0] LOCKSRC_ANALOG  = 3'h1;
  localparam logic [2:0] LOCKSRC_REFDIV  = 3'h2;
  localparam logic [2:0] LOCKSRC_FBDIV   = 3'h3;
  localparam logic [2:0] LOCKSRC_TEST    = 3'h4;
  localparam logic [2:0] LOCK_CYCLES = 3'h5;
endpackage

// *** design/psd_sync.sv ***
// Purpose: Two-flop synchroniser with rising-edge detect, one per input bit
// Assumes: Inputs are asynchronous to clk
// Notes:   The first stage feeds only the second stage
`timescale 1ns/1ps
`default_nettype none
module psd_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out,
  output logic      [W-1:0] rise
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
  } psd_sync_st_t;
  psd_sync_st_t st_reg;
  psd_sync_st_t st_next;

  // Shift the pins through the stages
  always_comb begin
    st_next = st_reg;
    st_next.s1 = async_in;
    st_next.s2 = st_reg.s1;
    st_next.s3 = st_reg.s2;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // Edge found between stage two and three
  assign sync_out = st_reg.s2;
  assign rise     = st_reg.s2 & ~st_reg.s3;
endmodule
`default_nettype wire

// *** design/psd_top.sv ***
// Purpose: Digital control side of an integer-N synthesizer: serial load,
//          reference and feedback dividers, phase detector, lock pin mux
// Assumes: All pins asynchronous; sampled by clk at 10 MHz. Divider inputs
//          are seen as sampled edges, so they must run well below clk/2
// Notes:   chip_enable low gates pump and lock pin at once, counters after sync
// Function
// - Each serial data bit is shifted in on a rising edge of the serial clock.
// - Words arrive MSB first and the last bit shifted is the register select.
// - A rising load strobe copies the shift register into the selected register.
// - The shifter is 18 bits; select 0 loads 17 bits to feedback, 1 loads 15 to reference.
// - Chip enable low powers down at once and floats the pump output; here only pump and lock pin act at once, the counters after the sync.
// - The lock pin shows reference divider, feedback divider, digital or analog lock.
// - Lock source 000 digital, 001 analog, 010 reference, 011 feedback, 100 test.
// - The reference divider is a 10-bit counter dividing by 2 to 1023.
// - The reference divider is clocked from the reference oscillator input.
// - The comparison rate must stay at or below 10 MHz through the chosen ratio.
// - The phase detector compares the two divided signals and steers the pump.
// - When locked the oscillator equals feedback ratio times comparison rate.
// - The feedback path starts with a 32/33 dual-modulus prescaler.
`timescale 1ns/1ps
`default_nettype none
module psd_top (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic serial_clock,
  input  wire logic serial_data,
  input  wire logic load_strobe,
  input  wire logic chip_enable,
  input  wire logic reference_osc_input,
  input  wire logic rf_feedback_input,
  input  wire logic rf_feedback_input_complement,
  output logic      pump_up,
  output logic      pump_down,
  output logic      pump_output_oe_n,
  output logic      lock_status_pin,
  output logic      lock_status_pin_oe_n,
  output logic      reference_compare_signal,
  output logic      feedback_compare_signal
);
  localparam int N_PIN = 6;

  typedef struct packed {
    logic [psd_pkg::SHIFT_W-1:0] shifter;
    logic [psd_pkg::FB_W-1:0]    fb_word;
    logic [psd_pkg::REF_W:0]     ref_word;  // Shifter bits 15:1, top lock source bit kept
    logic [psd_pkg::RCNT_W-1:0]  ref_cnt;
    logic                        ref_out;
    logic [5:0]                  presc_cnt;
    logic [psd_pkg::FB_B_W-1:0]  b_cnt;
    logic [psd_pkg::FB_A_W-1:0]  a_cnt;
    logic                        fb_out;
    logic                        pfd_up;
    logic                        pfd_dn;
    logic [2:0]                  good_cnt;
    logic                        locked;
    logic                        pump_seen;
    logic                        analog_lock;
  } psd_st_t;

  psd_st_t st_reg;
  psd_st_t st_next;

  logic [N_PIN-1:0] pins_raw;
  logic [N_PIN-1:0] pins_s;
  logic [N_PIN-1:0] pins_r;
  logic             ce_s;
  logic [9:0]       r_ratio;
  logic [2:0]       lock_src;
  logic             pd_pol;
  logic             cp_tri;
  logic             pwdn;
  logic             ref_tick;
  logic             fb_tick;
  logic             power_dn;
  logic             lock_pd;

  // Outside inputs pass two flops before use; chip_enable also gates pump and lock pin directly
  assign pins_raw = {chip_enable, rf_feedback_input, reference_osc_input,
                     load_strobe, serial_data, serial_clock};
  psd_sync #(.W(N_PIN)) u_sync (
    .clk      (clk),
    .rst_n    (rst_n),
    .async_in (pins_raw),
    .sync_out (pins_s),
    .rise     (pins_r)
  );
  assign ce_s = pins_s[5];

  // Decoded fields of the held registers
  assign r_ratio = st_reg.ref_word[psd_pkg::RCNT_LSB-1 +: psd_pkg::RCNT_W];
  assign cp_tri  = st_reg.ref_word[psd_pkg::CPTRI_BIT-1];
  assign pd_pol  = st_reg.ref_word[psd_pkg::PDPOL_BIT-1];
  assign lock_src = st_reg.ref_word[psd_pkg::LOCKSRC_LSB-1 +: 3];
  assign pwdn    = st_reg.fb_word[psd_pkg::FB_PWDN_BIT-1];
  assign power_dn = pwdn | ~ce_s;
  // Lock pin blanks straight from the pin, like the pump, with no sync lag
  assign lock_pd  = pwdn | ~chip_enable;
  assign ref_tick = pins_r[3];
  assign fb_tick  = pins_r[4];

  // Next-state logic for serial port, dividers, detector and lock filter
  always_comb begin
    st_next = st_reg;
    if (pins_r[0]) begin
      st_next.shifter = {st_reg.shifter[psd_pkg::SHIFT_W-2:0], pins_s[1]};
    end
    if (pins_r[2]) begin
      if (st_reg.shifter[0]) begin
        st_next.ref_word = st_reg.shifter[psd_pkg::REF_W+1:1];
      end else begin
        st_next.fb_word = st_reg.shifter[psd_pkg::SHIFT_W-1:1];
      end
    end
    st_next.ref_out = 1'b0;
    st_next.fb_out  = 1'b0;
    if (power_dn) begin
      // Power-down resets both dividers so they restart aligned
      st_next.ref_cnt   = '0;
      st_next.presc_cnt = '0;
      st_next.b_cnt     = '0;
      st_next.a_cnt     = '0;
      st_next.pfd_up    = 1'b0;
      st_next.pfd_dn    = 1'b0;
      st_next.good_cnt  = '0;
      st_next.locked    = 1'b0;
    end else begin
      // Reference divider counts oscillator edges
      if (ref_tick) begin
        if (st_reg.ref_cnt + 10'h001 >= r_ratio || r_ratio < psd_pkg::RCNT_MIN) begin
          st_next.ref_cnt = '0;
          st_next.ref_out = 1'b1;
        end else begin
          st_next.ref_cnt = st_reg.ref_cnt + 10'h001;
        end
      end
      // Prescaler divides by 33 while A runs, else by 32
      if (fb_tick) begin
        if ({26'h0, st_reg.presc_cnt} + 32'h1 >=
            psd_pkg::PRESC_LOW + ((st_reg.a_cnt != '0) ? 1 : 0)) begin
          st_next.presc_cnt = '0;
          if (st_reg.b_cnt + 10'h001 >= st_reg.fb_word[psd_pkg::FB_B_LSB-1 +: psd_pkg::FB_B_W]) begin
            st_next.b_cnt  = '0;
            st_next.a_cnt  = st_reg.fb_word[psd_pkg::FB_A_LSB-1 +: psd_pkg::FB_A_W];
            st_next.fb_out = 1'b1;
          end else begin
            st_next.b_cnt = st_reg.b_cnt + 10'h001;
            if (st_reg.a_cnt != '0) begin
              st_next.a_cnt = st_reg.a_cnt - 5'h01;
            end
          end
        end else begin
          st_next.presc_cnt = st_reg.presc_cnt + 6'h01;
        end
      end
      // Three-state phase/frequency detector
      if (st_reg.ref_out) begin
        st_next.pfd_up = 1'b1;
      end
      if (st_reg.fb_out) begin
        st_next.pfd_dn = 1'b1;
      end
      if ((st_reg.pfd_up | st_reg.ref_out) & (st_reg.pfd_dn | st_reg.fb_out)) begin
        st_next.pfd_up = 1'b0;
        st_next.pfd_dn = 1'b0;
      end
      // Digital lock: five clean comparison cycles in a row
      if (st_reg.ref_out) begin
        if (!st_reg.pump_seen && st_reg.good_cnt != psd_pkg::LOCK_CYCLES) begin
          st_next.good_cnt = st_reg.good_cnt + 3'h1;
        end else if (st_reg.pump_seen) begin
          st_next.good_cnt = '0;
        end
        st_next.locked = st_reg.pump_seen ? 1'b0 :
                         (st_reg.good_cnt + 3'h1 >= psd_pkg::LOCK_CYCLES) | st_reg.locked;
      end
    end
    // Analog lock follows pump activity every clk cycle
    st_next.analog_lock = ~(st_reg.pfd_up | st_reg.pfd_dn);
    if (st_reg.ref_out) begin
      st_next.pump_seen = 1'b0;
    end else if (st_reg.pfd_up ^ st_reg.pfd_dn) begin
      // A one-sided pump pulse in any cycle without ref_out marks this comparison cycle as unclean
      st_next.pump_seen = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_reg          <= '0;
      st_reg.fb_word  <= psd_pkg::FB_RESET;
      st_reg.ref_word <= {1'b0, psd_pkg::REF_RESET};
    end else begin
      st_reg <= st_next;
    end
  end

  // Pump drive: polarity swap, high impedance on power-down or CP_TRI bit
  assign pump_up   = ~chip_enable ? 1'b0 : (pd_pol ? st_reg.pfd_up : st_reg.pfd_dn);
  assign pump_down = ~chip_enable ? 1'b0 : (pd_pol ? st_reg.pfd_dn : st_reg.pfd_up);
  assign pump_output_oe_n = ~chip_enable | power_dn | cp_tri |
                            ~(st_reg.pfd_up ^ st_reg.pfd_dn);
  assign reference_compare_signal = st_reg.ref_out;
  assign feedback_compare_signal  = st_reg.fb_out;

  // Lock pin source select; analog mode drives open-drain
  always_comb begin
    lock_status_pin      = 1'b1;
    lock_status_pin_oe_n = 1'b0;
    if (lock_pd) begin
      lock_status_pin = 1'b1;
    end else begin
      case (lock_src)
        psd_pkg::LOCKSRC_DIGITAL: lock_status_pin = st_reg.locked;
        psd_pkg::LOCKSRC_ANALOG: begin
          lock_status_pin      = 1'b0;
          lock_status_pin_oe_n = st_reg.analog_lock;
        end
        psd_pkg::LOCKSRC_REFDIV:  lock_status_pin = st_reg.ref_out;
        psd_pkg::LOCKSRC_FBDIV:   lock_status_pin = st_reg.fb_out;
        psd_pkg::LOCKSRC_TEST:    lock_status_pin = st_reg.locked;
        default:                  lock_status_pin = st_reg.locked;
      endcase
    end
  end
endmodule
`default_nettype wire

// *** verif/psd_host.sv ***
// Purpose: Host model driving the three-wire programming port
// Assumes: Serial clock period 800 ns, eight bench clocks
// Notes:   Serial clock stands low between words
`timescale 1ns/1ps
`default_nettype none
module psd_host (
  input  wire logic clk,
  output var logic  serial_clock,
  output var logic  serial_data,
  output var logic  load_strobe
);
  // Idle levels at time zero
  initial begin
    serial_clock = 1'b0;
    serial_data  = 1'b0;
    load_strobe  = 1'b0;
  end
  // Shift a word, then raise the strobe once the select bit is in
  task automatic send(input logic [17:0] w);
    @(posedge clk);
    for (int i = 17; i >= 0; i--) begin
      #5 serial_clock = 1'b0;
      serial_data = w[i];
      repeat (4) @(posedge clk);
      #5 serial_clock = 1'b1;
      repeat (4) @(posedge clk);
    end
    #5 serial_clock = 1'b0;
    serial_data = ~w[0]; // Released line shows the inverse
    repeat (4) @(posedge clk);
    #5 load_strobe = 1'b1;
    repeat (4) @(posedge clk);
    #5 load_strobe = 1'b0;
  endtask
endmodule
`default_nettype wire

// *** verif/psd_checker.sv ***
// Purpose: Port assertions for the synthesizer control block
// Assumes: Single clock domain, synchronous reset
// Notes:   Bound to psd_top below
`timescale 1ns/1ps
`default_nettype none
module psd_checker (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic chip_enable,
  input wire logic pump_up,
  input wire logic pump_down,
  input wire logic pump_output_oe_n,
  input wire logic lock_status_pin,
  input wire logic lock_status_pin_oe_n,
  input wire logic reference_compare_signal,
  input wire logic feedback_compare_signal
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Power held down for four samples, past the pin synchroniser and one register
  sequence ce_low4;
    !chip_enable [*4];
  endsequence
  // Reset just released while powered
  sequence rst_done;
    $rose(rst_n) && chip_enable;
  endsequence
  pd_tristate_a: assert property (!chip_enable |-> pump_output_oe_n)
    else $error("pump driven while powered down");
  pd_pump_idle_a: assert property (!chip_enable |-> !pump_up && !pump_down)
    else $error("pump steered while powered down");
  pd_lock_high_a: assert property (!chip_enable |-> lock_status_pin)
    else $error("lock pin low while powered down");
  pd_cnt_quiet_a: assert property (ce_low4 |-> !reference_compare_signal && !feedback_compare_signal)
    else $error("compare pulse while powered down");
  ref_pulse_a: assert property (reference_compare_signal |=> !reference_compare_signal)
    else $error("reference pulse wider than one cycle");
  fb_pulse_a: assert property ($rose(feedback_compare_signal) |=> $fell(feedback_compare_signal))
    else $error("feedback pulse wider than one cycle");
  rst_pump_a: assert property (rst_done |-> pump_output_oe_n && !pump_up && !pump_down)
    else $error("pump active after reset");
  rst_lock_a: assert property (rst_done |-> !lock_status_pin && !lock_status_pin_oe_n)
    else $error("lock pin not digital lock after reset");
endmodule
bind psd_top psd_checker i_chk (.clk(clk), .rst_n(rst_n), .chip_enable(chip_enable),
  .pump_up(pump_up), .pump_down(pump_down), .pump_output_oe_n(pump_output_oe_n),
  .lock_status_pin(lock_status_pin), .lock_status_pin_oe_n(lock_status_pin_oe_n),
  .reference_compare_signal(reference_compare_signal),
  .feedback_compare_signal(feedback_compare_signal));
`default_nettype wire

// *** verif/tb_psd_top.sv ***
// Purpose: Self-checking bench for the synthesizer control block
// Assumes: 10 MHz clk, oscillator 1 MHz, RF input 1.67 MHz
// Notes:   Divider periods measured between second and third pulse
`timescale 1ns/1ps
`default_nettype none
module tb_psd_top;
  logic        clk, rst_n, chip_enable, osc, rf, sclk, sdata, strobe;
  logic        up, down, cp_oe_n, lock, lock_oe_n, ref_cmp, fb_cmp;
  int          n_mismatch, checked, cyc, ref_n, fb_n, ref_t, fb_t;
  logic [31:0] ref_q[$];
  logic [31:0] fb_q[$];
  logic [9:0]  ratio;
  logic [4:0]  a_cnt;
  psd_host i_host (.clk(clk), .serial_clock(sclk), .serial_data(sdata), .load_strobe(strobe));
  psd_top i_dut (.clk(clk), .rst_n(rst_n), .serial_clock(sclk), .serial_data(sdata),
    .load_strobe(strobe), .chip_enable(chip_enable), .reference_osc_input(osc),
    .rf_feedback_input(rf), .rf_feedback_input_complement(1'b0), .pump_up(up),
    .pump_down(down), .pump_output_oe_n(cp_oe_n), .lock_status_pin(lock),
    .lock_status_pin_oe_n(lock_oe_n), .reference_compare_signal(ref_cmp),
    .feedback_compare_signal(fb_cmp));
  // Clock and the two divider inputs
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial begin
    osc = 1'b0;
    forever #500 osc = ~osc;
  end
  initial begin
    rf = 1'b0;
    forever #300 rf = ~rf;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic final_report();
    $display("checked %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // Bounded wait until all noted periods are compared
  task automatic wait_idle();
    for (int i = 0; i < 5000 && ref_q.size() + fb_q.size() > 0; i++) @(posedge clk);
    if (ref_q.size() + fb_q.size() > 0) begin
      n_mismatch++;
      final_report();
    end
  endtask
  // Measure divider periods on the falling edge, clear of the register update
  always @(negedge clk) begin
    cyc <= cyc + 1;
    if (ref_cmp === 1'b1 && ref_q.size() > 0) begin
      ref_n = ref_n + 1;
      if (ref_n == 2) ref_t = cyc;
      if (ref_n == 3) begin
        check(32'(cyc - ref_t), ref_q.pop_front());
        ref_n = 0;
      end
    end
    if (fb_cmp === 1'b1 && fb_q.size() > 0) begin
      fb_n = fb_n + 1;
      if (fb_n == 2) fb_t = cyc;
      if (fb_n == 3) begin
        check(32'(cyc - fb_t), fb_q.pop_front());
        fb_n = 0;
      end
    end
  end
  // Main sequence
  initial begin
    rst_n = 1'b0;
    chip_enable = 1'b1;
    void'($urandom(32'h5B07));
    repeat (16) @(posedge clk);
    #5 rst_n = 1'b1;
    a_cnt = 5'($urandom % 3);
    i_host.send({1'b0, 10'h002, a_cnt, 2'b00});
    for (int k = 0; k < 5; k++) begin
      ratio = (k == 0) ? 10'h002 : 10'($urandom_range(9, 3));
      i_host.send({2'b00, 3'(k), 2'b10, ratio, 1'b1});
      repeat (6) @(posedge clk);
      ref_q.push_back(32'(ratio) * 10);
      fb_q.push_back((64 + 32'(a_cnt)) * 6);
      wait_idle();
      $display("test lock source %0d done", k);
    end
    #5 chip_enable = 1'b0;
    repeat (3) @(posedge clk);
    #5 check({31'h0, cp_oe_n}, 32'h1);
    check({31'h0, lock}, 32'h1);
    chip_enable = 1'b1;
    $display("test power down done");
    repeat (20) @(posedge clk);
    final_report();
  end
endmodule
`default_nettype wire
